// >>> rtl/auxrb_device.sv
// Device end: decodes bridged requests into internal 32-bit register accesses.
// Assumes register read data is valid in the same cycle as reg_rd_en; external forwarding
// partner answers on the ext_rsp stream.
//
// Summary of operation
// - Source uses only transaction method two.
// - Header: command, zeros, target address, length.
// - Command 0 writes, command 1 reads.
// - Own target address selects internal registers.
// - Length byte equals payload bytes minus one.
// - First two write bytes: address, MSB first.
// - Data words sent least significant byte first.
// - Each further written word goes four higher.
// - Address-only write loads the read offset.
// - Offset advances four after each read word.
// - Target by default; master mode forwards requests for other targets externally.
// - Reply starts with ack codes, then data.
// - Own address 0x68, strapped 0x0E.
`timescale 1ns/1ns
module auxrb_device
	import auxrb_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// Link to the source
	auxrb_link_if.dev        link,
	// Configuration
	input  wire logic        address_strap_pin,
	input  wire logic        i2c_master_en,
	// I2C clock pin
	output logic             scl_o,
	output logic             scl_oe,
	// Internal register port
	output logic             reg_wr_en,
	output logic             reg_rd_en,
	output logic [15:0]      reg_addr,
	output logic [31:0]      reg_wdata,
	input  wire logic [31:0] reg_rdata,
	// External forwarding port
	output logic             ext_start,
	output logic [3:0]       ext_cmd,
	output logic [6:0]       ext_target,
	output logic [7:0]       ext_len,
	output logic             ext_req_valid,
	output logic [7:0]       ext_req_byte,
	output logic             ext_req_last,
	input  wire logic        ext_rsp_valid,
	input  wire logic [7:0]  ext_rsp_byte,
	input  wire logic        ext_rsp_last
);

	// ==========================================
	// State
	auxrb_dev_state_e st_r;
	logic             strap_done_r;
	logic             strap_r;
	logic [3:0]       cmd_r;
	logic [6:0]       tgt_r;
	logic [7:0]       len_r;
	logic [7:0]       cnt_r;
	logic [15:0]      ofs_r;
	logic [15:0]      waddr_r;
	logic [31:0]      sh_r;
	logic             hdr_sent_r;
	logic [1:0]       ack_r;
	logic             rsp_valid_r;
	logic [7:0]       rsp_byte_r;
	logic             rsp_last_r;

	// ==========================================
	// Decode
	wire logic [6:0] own_tgt   = strap_r ? TGT_STRAPPED : TGT_DEFAULT;
	wire logic       is_own    = (tgt_r == own_tgt);
	wire logic       is_wr     = (cmd_r == CMD_WRITE);
	wire logic       is_rd     = (cmd_r == CMD_READ);
	wire logic       is_fwd    = i2c_master_en && !is_own;
	wire logic       byte_in   = link.req_valid;
	wire logic       last_in   = link.req_valid && link.req_last;
	wire logic [7:0] data_idx  = cnt_r - 8'h02;
	wire logic       word_done = (cnt_r > 8'h01) && (data_idx[1:0] == BYTE_LAST_IDX);
	wire logic       rd_last   = (cnt_r == len_r);
	wire logic [7:0] ack_byte  = {ack_r, ACK_OK, 4'h0};

	assign link.rsp_valid = rsp_valid_r;
	assign link.rsp_byte  = rsp_byte_r;
	assign link.rsp_last  = rsp_last_r;

	// ==========================================
	// Strap capture after reset release
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			strap_done_r <= 1'b0;
			strap_r      <= 1'b0;
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			strap_r      <= address_strap_pin;
		end
	end

	// ==========================================
	// I2C clock pin: input until master mode
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			scl_oe <= 1'b0;
			scl_o  <= 1'b0;
		end else begin
			scl_oe <= i2c_master_en;
			scl_o  <= 1'b0;
		end
	end

	// ==========================================
	// Request decode and reply
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_r          <= DS_HDR0;
			cmd_r         <= 4'h0;
			tgt_r         <= 7'h00;
			len_r         <= 8'h00;
			cnt_r         <= 8'h00;
			ofs_r         <= OFS_RESET;
			waddr_r       <= OFS_RESET;
			sh_r          <= 32'h0000_0000;
			hdr_sent_r    <= 1'b0;
			ack_r         <= ACK_OK;
			rsp_valid_r   <= 1'b0;
			rsp_byte_r    <= 8'h00;
			rsp_last_r    <= 1'b0;
			reg_wr_en     <= 1'b0;
			reg_rd_en     <= 1'b0;
			reg_addr      <= 16'h0000;
			reg_wdata     <= 32'h0000_0000;
			ext_start     <= 1'b0;
			ext_cmd       <= 4'h0;
			ext_target    <= 7'h00;
			ext_len       <= 8'h00;
			ext_req_valid <= 1'b0;
			ext_req_byte  <= 8'h00;
			ext_req_last  <= 1'b0;
		end else begin
			rsp_valid_r   <= 1'b0;
			rsp_last_r    <= 1'b0;
			reg_wr_en     <= 1'b0;
			reg_rd_en     <= 1'b0;
			ext_start     <= 1'b0;
			ext_req_valid <= 1'b0;
			ext_req_last  <= 1'b0;
			case (st_r)
				DS_HDR0: begin
					if (byte_in) begin
						cmd_r <= link.req_byte[7:4];
						st_r  <= DS_HDR1;
					end
				end
				DS_HDR1: begin
					if (byte_in) begin
						st_r <= DS_HDR2;
					end
				end
				DS_HDR2: begin
					if (byte_in) begin
						tgt_r <= link.req_byte[6:0];
						st_r  <= DS_LEN;
					end
				end
				DS_LEN: begin
					if (byte_in) begin
						len_r      <= link.req_byte;
						cnt_r      <= 8'h00;
						hdr_sent_r <= 1'b0;
						ack_r      <= ACK_OK;
						if (is_fwd) begin
							ext_start  <= 1'b1;
							ext_cmd    <= cmd_r;
							ext_target <= tgt_r;
							ext_len    <= link.req_byte;
							st_r       <= link.req_last ? DS_FWAIT : DS_FWD;
						end else if (!is_own || !(is_wr || is_rd)) begin
							ack_r <= ACK_NACK;
							st_r  <= link.req_last ? DS_RSP : DS_DRAIN;
						end else if (is_wr) begin
							st_r <= link.req_last ? DS_RSP : DS_WDATA;
						end else begin
							st_r <= link.req_last ? DS_RFETCH : DS_DRAIN;
						end
					end
				end
				DS_WDATA: begin
					if (byte_in) begin
						cnt_r <= cnt_r + 8'h01;
						if (cnt_r == 8'h00) begin
							waddr_r[15:8] <= link.req_byte;
						end else if (cnt_r == 8'h01) begin
							waddr_r[7:0] <= link.req_byte;
							ofs_r        <= {waddr_r[15:8], link.req_byte};
						end else begin
							sh_r <= {link.req_byte, sh_r[31:8]};
						end
						if (word_done) begin
							reg_wr_en <= 1'b1;
							reg_addr  <= waddr_r;
							reg_wdata <= {link.req_byte, sh_r[31:8]};
							waddr_r   <= waddr_r + WORD_STEP;
						end
						if (link.req_last) begin
							st_r <= DS_RSP;
						end
					end
				end
				DS_DRAIN: begin
					if (last_in) begin
						st_r <= DS_RSP;
					end
				end
				DS_RSP: begin
					rsp_valid_r <= 1'b1;
					rsp_byte_r  <= ack_byte;
					rsp_last_r  <= 1'b1;
					st_r        <= DS_HDR0;
				end
				DS_RFETCH: begin
					reg_rd_en <= 1'b1;
					reg_addr  <= ofs_r;
					if (!hdr_sent_r) begin
						rsp_valid_r <= 1'b1;
						rsp_byte_r  <= ack_byte;
						hdr_sent_r  <= 1'b1;
					end
					st_r <= DS_RLOAD;
				end
				DS_RLOAD: begin
					sh_r <= reg_rdata;
					st_r <= DS_RSEND;
				end
				DS_RSEND: begin
					rsp_valid_r <= 1'b1;
					rsp_byte_r  <= sh_r[7:0];
					rsp_last_r  <= rd_last;
					sh_r        <= {8'h00, sh_r[31:8]};
					cnt_r       <= cnt_r + 8'h01;
					if (cnt_r[1:0] == BYTE_LAST_IDX) begin
						ofs_r <= ofs_r + WORD_STEP;
					end
					if (rd_last) begin
						st_r <= DS_HDR0;
					end else if (cnt_r[1:0] == BYTE_LAST_IDX) begin
						st_r <= DS_RFETCH;
					end
				end
				DS_FWD: begin
					ext_req_valid <= byte_in;
					ext_req_byte  <= link.req_byte;
					ext_req_last  <= last_in;
					if (last_in) begin
						st_r <= DS_FWAIT;
					end
				end
				DS_FWAIT: begin
					// Reply from the external target passes through unchanged
					rsp_valid_r <= ext_rsp_valid;
					rsp_byte_r  <= ext_rsp_byte;
					rsp_last_r  <= ext_rsp_valid && ext_rsp_last;
					if (ext_rsp_valid && ext_rsp_last) begin
						st_r <= DS_HDR0;
					end
				end
				default: begin
					st_r <= DS_HDR0;
				end
			endcase
		end
	end

endmodule : auxrb_device

// >>> rtl/auxrb_link_if.sv
// Byte-level AUX sideband link between the source controller and the bridge.
// Assumes both ends share ref_clk; each side accepts a valid byte in any cycle.
`timescale 1ns/1ns
interface auxrb_link_if;
	// Request bytes, source to device
	logic       req_valid;
	logic [7:0] req_byte;
	logic       req_last;
	// Reply bytes, device to source
	logic       rsp_valid;
	logic [7:0] rsp_byte;
	logic       rsp_last;

	modport dev (
		input  req_valid,
		input  req_byte,
		input  req_last,
		output rsp_valid,
		output rsp_byte,
		output rsp_last
	);

	modport src (
		output req_valid,
		output req_byte,
		output req_last,
		input  rsp_valid,
		input  rsp_byte,
		input  rsp_last
	);
endinterface : auxrb_link_if

// >>> rtl/auxrb_pkg.sv
// Constants, encodings and state types shared by both ends of the AUX register bridge.
// Assumes one 50 MHz clock (ref_clk) and a synchronous active-high reset at both ends.
package auxrb_pkg;

	// ==========================================
	// Commands and addressing
	localparam logic [3:0]  CMD_WRITE     = 4'h0;   // bridged_write_request
	localparam logic [3:0]  CMD_READ      = 4'h1;   // bridged_read_request
	localparam logic [6:0]  TGT_DEFAULT   = 7'h68;
	localparam logic [6:0]  TGT_STRAPPED  = 7'h0E;
	localparam logic [15:0] WORD_STEP     = 16'h0004;
	localparam logic [15:0] OFS_RESET     = 16'h0000;

	// ==========================================
	// Reply acknowledge codes
	localparam logic [1:0]  ACK_OK        = 2'h0;
	localparam logic [1:0]  ACK_NACK      = 2'h1;

	// ==========================================
	// Transfer limits
	localparam logic [1:0]  HDR_LAST_IDX  = 2'h3;
	localparam logic [1:0]  BYTE_LAST_IDX = 2'h3;

	// ==========================================
	// State types
	typedef enum logic [3:0] {
		DS_HDR0   = 4'b0000,
		DS_HDR1   = 4'b0001,
		DS_HDR2   = 4'b0010,
		DS_LEN    = 4'b0011,
		DS_WDATA  = 4'b0100,
		DS_RSP    = 4'b0101,
		DS_RFETCH = 4'b0110,
		DS_RLOAD  = 4'b0111,
		DS_RSEND  = 4'b1000,
		DS_FWD    = 4'b1001,
		DS_FWAIT  = 4'b1010,
		DS_DRAIN  = 4'b1011
	} auxrb_dev_state_e;

	typedef enum logic [2:0] {
		HS_IDLE  = 3'b000,
		HS_HDR   = 3'b001,
		HS_ADR   = 3'b010,
		HS_WGET  = 3'b011,
		HS_WSEND = 3'b100,
		HS_WAIT  = 3'b101
	} auxrb_host_state_e;

endpackage : auxrb_pkg

// >>> rtl/auxrb_source.sv
// Source end: turns word-level user requests into bridged requests on the link.
// Assumes the device answers every request with exactly one reply ending in rsp_last.
`timescale 1ns/1ns
module auxrb_source
	import auxrb_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// Link to the device
	auxrb_link_if.src        link,
	// Request from user
	input  wire logic        go,
	input  wire logic        rd,
	input  wire logic [6:0]  target,
	input  wire logic [15:0] addr,
	input  wire logic [2:0]  nwords,
	// Write words from user
	input  wire logic        wvalid,
	input  wire logic [31:0] wdata,
	output logic             wready,
	// Results to user
	output logic             busy,
	output logic             done,
	output logic [3:0]       status,
	output logic             rvalid,
	output logic [31:0]      rdata
);

	// ==========================================
	// State
	auxrb_host_state_e st_r;
	logic              rd_r;
	logic [6:0]        tgt_r;
	logic [15:0]       addr_r;
	logic [2:0]        left_r;
	logic [1:0]        idx_r;
	logic [31:0]       sh_r;
	logic              first_r;
	logic              req_valid_r;
	logic [7:0]        req_byte_r;
	logic              req_last_r;

	// ==========================================
	// Header bytes; only single-transaction commands are ever issued
	wire logic [3:0] cmd_sel  = rd_r ? CMD_READ : CMD_WRITE;
	wire logic [7:0] len_rd   = {3'h0, left_r, 2'h0} - 8'h01;
	wire logic [7:0] len_wr   = {3'h0, left_r, 2'h0} + 8'h01;
	wire logic [7:0] hdr_byte = (idx_r == 2'h0) ? {cmd_sel, 4'h0} :
	                            (idx_r == 2'h1) ? 8'h00 :
	                            (idx_r == 2'h2) ? {1'b0, tgt_r} :
	                            (rd_r ? len_rd : len_wr);

	assign link.req_valid = req_valid_r;
	assign link.req_byte  = req_byte_r;
	assign link.req_last  = req_last_r;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_r        <= HS_IDLE;
			rd_r        <= 1'b0;
			tgt_r       <= 7'h00;
			addr_r      <= 16'h0000;
			left_r      <= 3'h0;
			idx_r       <= 2'h0;
			sh_r        <= 32'h0000_0000;
			first_r     <= 1'b0;
			req_valid_r <= 1'b0;
			req_byte_r  <= 8'h00;
			req_last_r  <= 1'b0;
			wready      <= 1'b0;
			busy        <= 1'b0;
			done        <= 1'b0;
			status      <= 4'h0;
			rvalid      <= 1'b0;
			rdata       <= 32'h0000_0000;
		end else begin
			req_valid_r <= 1'b0;
			req_last_r  <= 1'b0;
			done        <= 1'b0;
			rvalid      <= 1'b0;
			case (st_r)
				HS_IDLE: begin
					if (go) begin
						rd_r   <= rd;
						tgt_r  <= target;
						addr_r <= addr;
						left_r <= nwords;
						idx_r  <= 2'h0;
						busy   <= 1'b1;
						st_r   <= HS_HDR;
					end
				end
				HS_HDR: begin
					req_valid_r <= 1'b1;
					req_byte_r  <= hdr_byte;
					req_last_r  <= rd_r && (idx_r == HDR_LAST_IDX);
					idx_r       <= idx_r + 2'h1;
					if (idx_r == HDR_LAST_IDX) begin
						first_r <= 1'b1;
						st_r    <= rd_r ? HS_WAIT : HS_ADR;
					end
				end
				HS_ADR: begin
					req_valid_r <= 1'b1;
					req_byte_r  <= idx_r[0] ? addr_r[7:0] : addr_r[15:8];
					req_last_r  <= idx_r[0] && (left_r == 3'h0);
					idx_r       <= idx_r + 2'h1;
					if (idx_r[0]) begin
						idx_r  <= 2'h0;
						wready <= (left_r != 3'h0);
						st_r   <= (left_r == 3'h0) ? HS_WAIT : HS_WGET;
					end
				end
				HS_WGET: begin
					if (wvalid && wready) begin
						wready <= 1'b0;
						sh_r   <= wdata;
						st_r   <= HS_WSEND;
					end
				end
				HS_WSEND: begin
					req_valid_r <= 1'b1;
					req_byte_r  <= sh_r[7:0];
					req_last_r  <= (idx_r == BYTE_LAST_IDX) && (left_r == 3'h1);
					sh_r        <= {8'h00, sh_r[31:8]};
					idx_r       <= idx_r + 2'h1;
					if (idx_r == BYTE_LAST_IDX) begin
						left_r <= left_r - 3'h1;
						wready <= (left_r != 3'h1);
						st_r   <= (left_r == 3'h1) ? HS_WAIT : HS_WGET;
					end
				end
				HS_WAIT: begin
					if (link.rsp_valid) begin
						first_r <= 1'b0;
						if (first_r) begin
							status <= link.rsp_byte[7:4];
						end else begin
							rdata <= {link.rsp_byte, rdata[31:8]};
							idx_r <= idx_r + 2'h1;
							rvalid <= (idx_r == BYTE_LAST_IDX);
						end
						if (link.rsp_last) begin
							done <= 1'b1;
							busy <= 1'b0;
							st_r <= HS_IDLE;
						end
					end
				end
				default: begin
					st_r <= HS_IDLE;
				end
			endcase
		end
	end

endmodule : auxrb_source

// >>> test/auxrb_link_props.sv
// Concurrent checks on the byte link that joins the source and device ends.
// Assumes one clock and the synchronous active-high reset shared by both ends.
`timescale 1ns/1ns
module auxrb_link_props
	import auxrb_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       srst,
	// Request bytes
	input  wire logic       req_valid,
	input  wire logic [7:0] req_byte,
	input  wire logic       req_last,
	// Reply bytes
	input  wire logic       rsp_valid,
	input  wire logic [7:0] rsp_byte,
	input  wire logic       rsp_last
);
	// ==========================================
	// Frame trackers
	logic [7:0] req_idx_r;
	logic [7:0] rsp_idx_r;
	logic [3:0] cmd_r;
	logic [7:0] len_r;
	logic [7:0] ack_r;
	logic       pend_r;
	wire        is_rd = (cmd_r == CMD_READ);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			req_idx_r <= 8'h00;
			rsp_idx_r <= 8'h00;
			cmd_r     <= 4'h0;
			len_r     <= 8'h00;
			ack_r     <= 8'h00;
			pend_r    <= 1'b0;
		end else begin
			if (req_valid)
				req_idx_r <= req_last ? 8'h00 : req_idx_r + 8'h01;
			if (req_valid && req_idx_r == 8'h00)
				cmd_r <= req_byte[7:4];
			if (req_valid && req_idx_r == 8'h03)
				len_r <= req_byte;
			if (rsp_valid)
				rsp_idx_r <= rsp_last ? 8'h00 : rsp_idx_r + 8'h01;
			if (rsp_valid && rsp_idx_r == 8'h00)
				ack_r <= rsp_byte;
			// Set wins: a reply never ends in the cycle a request ends
			if (req_valid && req_last)
				pend_r <= 1'b1;
			else if (rsp_valid && rsp_last)
				pend_r <= 1'b0;
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	hdr_cmd_a: assert property (
		req_valid && req_idx_r == 8'h00 |-> req_byte[3:0] == 4'h0 && req_byte[7:5] == 3'h0)
		else $error("Bad command byte");
	hdr_zero_a: assert property (
		req_valid && req_idx_r == 8'h01 |-> req_byte == 8'h00)
		else $error("Second header byte not zero");
	hdr_tgt_a: assert property (
		req_valid && req_idx_r == 8'h02 |-> !req_byte[7])
		else $error("Target byte top bit set");
	req_len_a: assert property (
		req_valid && req_last |-> (is_rd ? req_idx_r == 8'h03 : req_idx_r == len_r + 8'h04))
		else $error("Request length mismatch");
	req_order_a: assert property (
		req_valid |-> !pend_r)
		else $error("Request sent before reply ended");
	rsp_order_a: assert property (
		rsp_valid |-> pend_r)
		else $error("Reply without request");
	req_done_a: assert property (
		req_valid && req_last |-> ##[2:30] rsp_valid)
		else $error("Reply missing");
	rsp_ack_a: assert property (
		rsp_valid && rsp_idx_r == 8'h00 |-> rsp_byte[3:0] == 4'h0 && !rsp_byte[7])
		else $error("Bad acknowledge byte");
	wr_single_a: assert property (
		rsp_valid && rsp_idx_r == 8'h00 && !is_rd |-> rsp_last)
		else $error("Write reply longer than one byte");
	rsp_count_a: assert property (
		rsp_valid && rsp_last && is_rd && rsp_idx_r != 8'h00 && ack_r[7:4] == 4'h0
		|-> rsp_idx_r == len_r + 8'h01)
		else $error("Read reply length mismatch");
endmodule : auxrb_link_props

// >>> test/test_aux_register_access_bridge.sv
// Bench joining source and device ends; models register file and external I2C side.
// Assumes the package and link interface are compiled first.
`timescale 1ns/1ns
module test_aux_register_access_bridge
	import auxrb_pkg::*;
;
	logic        ref_clk = 1'b0, srst = 1'b1, address_strap_pin = 1'b0, i2c_master_en = 1'b0;
	logic        go = 1'b0, rd = 1'b0, wvalid = 1'b0;
	logic [6:0]  target = 7'h00;
	logic [15:0] addr = 16'h0000;
	logic [2:0]  nwords = 3'd0, rnd_n;
	logic [31:0] wdata = 32'h0, reg_rdata;
	logic        ext_rsp_valid = 1'b0, ext_rsp_last = 1'b0;
	logic [7:0]  ext_rsp_byte = 8'h00, ext_k, ext_len_seen;
	logic [8:0]  ext_left = 9'd0;
	logic [6:0]  ext_tgt_seen, own;
	logic [3:0]  ext_cmd_seen, ext_cmd, status;
	logic [31:0] mem [0:255], expm [0:255], wq [0:3], rq [0:3], reg_wdata, rdata;
	logic [15:0] reg_addr, rnd_addr;
	logic [7:0]  ext_len;
	logic [6:0]  ext_target;
	logic        scl_o, scl_oe, reg_wr_en, reg_rd_en, ext_start, ext_req_last, ext_req_valid;
	logic        wready, busy, done, rvalid;
	logic [7:0]  reqq [$], extq [$], ext_req_byte;
	int          num_errors = 0, tests_run = 0, got;

	auxrb_link_if link_bus ();
	auxrb_device auxrb_device_inst (.ref_clk(ref_clk), .srst(srst), .link(link_bus.dev),
		.address_strap_pin(address_strap_pin), .i2c_master_en(i2c_master_en), .scl_o(scl_o),
		.scl_oe(scl_oe), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_start(ext_start), .ext_cmd(ext_cmd),
		.ext_target(ext_target), .ext_len(ext_len), .ext_req_valid(ext_req_valid),
		.ext_req_byte(ext_req_byte), .ext_req_last(ext_req_last),
		.ext_rsp_valid(ext_rsp_valid),
		.ext_rsp_byte(ext_rsp_byte), .ext_rsp_last(ext_rsp_last));
	auxrb_source auxrb_source_inst (.ref_clk(ref_clk), .srst(srst), .link(link_bus.src),
		.go(go), .rd(rd), .target(target), .addr(addr), .nwords(nwords), .wvalid(wvalid),
		.wdata(wdata), .wready(wready), .busy(busy), .done(done), .status(status),
		.rvalid(rvalid), .rdata(rdata));
	auxrb_link_props auxrb_link_props_inst (.ref_clk(ref_clk), .srst(srst),
		.req_valid(link_bus.req_valid), .req_byte(link_bus.req_byte),
		.req_last(link_bus.req_last), .rsp_valid(link_bus.rsp_valid),
		.rsp_byte(link_bus.rsp_byte), .rsp_last(link_bus.rsp_last));

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	// ==========================================
	// Register file, external target, request byte capture
	// Combinational read: the device loads the word while reg_rd_en stands
	assign reg_rdata = reg_rd_en ? mem[reg_addr[9:2]] : 32'h0;

	always @(posedge ref_clk) begin
		if (reg_wr_en) mem[reg_addr[9:2]] <= reg_wdata;
		if (ext_req_valid) extq.push_back(ext_req_byte);
		if (link_bus.req_valid) reqq.push_back(link_bus.req_byte);
		ext_rsp_valid <= 1'b0;
		ext_rsp_last  <= 1'b0;
		if (ext_start) begin
			ext_tgt_seen <= ext_target;
			ext_len_seen <= ext_len;
			ext_cmd_seen <= ext_cmd;
			ext_left     <= (ext_cmd == CMD_READ) ? {1'b0, ext_len} + 9'd2 : 9'd0;
			ext_k        <= 8'h00;
		end else if (ext_req_last) begin
			ext_left <= 9'd1;
		end else if (ext_left != 9'd0) begin
			ext_rsp_valid <= 1'b1;
			ext_rsp_byte  <= (ext_k == 8'h00) ? 8'h00 : 8'h9F + ext_k;
			ext_rsp_last  <= (ext_left == 9'd1);
			ext_left      <= ext_left - 9'd1;
			ext_k         <= ext_k + 8'h01;
		end
	end

	// ==========================================
	// Expectations and tasks
	function automatic logic [7:0] len_of(input logic r, input logic [2:0] n);
		return r ? {3'd0, n, 2'd0} - 8'h01 : {3'd0, n, 2'd0} + 8'h01;
	endfunction : len_of

	function automatic logic [31:0] fwd_word(input int i);
		logic [7:0] b;
		b = 8'hA0 + 8'(4 * i);
		return {b + 8'h03, b + 8'h02, b + 8'h01, b};
	endfunction : fwd_word

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check

	task automatic xfer(input logic r, input logic [6:0] t, input logic [15:0] a,
		input logic [2:0] n, input logic [3:0] st);
		int k;
		k = 0;
		got = 0;
		reqq.delete();
		extq.delete();
		// One idle edge keeps go and wvalid from being driven twice in one step
		@(posedge ref_clk);
		go <= 1'b1;
		rd <= r;
		target <= t;
		addr <= a;
		nwords <= n;
		repeat (400) begin
			wvalid <= !r && (k < n);
			wdata <= wq[k];
			@(posedge ref_clk);
			go <= 1'b0;
			if (wvalid === 1'b1 && wready === 1'b1) k++;
			if (rvalid === 1'b1 && got < 4) begin
				rq[got] = rdata;
				got++;
			end
			if (done === 1'b1) break;
		end
		wvalid <= 1'b0;
		check(done, 1'b1);
		check(status, st);
		check(reqq[0], {r ? CMD_READ : CMD_WRITE, 4'h0});
		check(reqq[1], 8'h00);
		check(reqq[2], {1'b0, t});
		check(reqq[3], len_of(r, n));
		check(reqq.size(), r ? 4 : len_of(r, n) + 5);
		if (!r) begin
			check(reqq[4], a[15:8]);
			check(reqq[5], a[7:0]);
		end
		if (!r && n != 3'd0) begin
			check(reqq[6], wq[0][7:0]);
			check(reqq[9], wq[0][31:24]);
		end
		if (!r && t == own && st == ACK_OK)
			for (int i = 0; i < n; i++) expm[a[9:2] + i] = wq[i];
	endtask : xfer

	task automatic rd_chk(input logic [15:0] a, input logic [2:0] n);
		xfer(1'b0, own, a, 3'd0, 4'h0);
		xfer(1'b1, own, 16'h0000, n, 4'h0);
		check(got, n);
		for (int i = 0; i < n; i++) check(rq[i], expm[a[9:2] + i]);
	endtask : rd_chk

	task automatic reset_dut(input logic s);
		srst <= 1'b1;
		address_strap_pin <= s;
		own = s ? TGT_STRAPPED : TGT_DEFAULT;
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check(scl_oe, 1'b0);
		check(scl_o, 1'b0);
		check(busy, 1'b0);
	endtask : reset_dut

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	// ==========================================
	// Tests
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		wrap_up();
	end

	initial begin
		void'($urandom(68757));
		reset_dut(1'b0);
		wq = '{32'h67452301, 32'hEFCDAB89, 32'h88885A5A, 32'h0};
		xfer(1'b0, own, 16'h0168, 3'd3, 4'h0);
		rd_chk(16'h0168, 3'd2);
		xfer(1'b1, own, 16'h0000, 3'd1, 4'h0);
		check(rq[0], 32'h88885A5A);
		$display("Example transfers done");
		xfer(1'b0, own, 16'h0200, 3'd3, 4'h0);
		xfer(1'b0, own, 16'h020C, 3'd1, 4'h0);
		rd_chk(16'h0200, 3'd4);
		for (int j = 0; j < 8; j++) begin
			for (int i = 0; i < 4; i++) wq[i] = $urandom;
			rnd_addr = {6'h00, 8'($urandom_range(0, 250)), 2'b00};
			rnd_n = 3'($urandom_range(1, 3));
			xfer(1'b0, own, rnd_addr, rnd_n, 4'h0);
			rd_chk(rnd_addr, rnd_n);
		end
		$display("Random transfers done");
		xfer(1'b0, 7'h11, 16'h0010, 3'd1, {ACK_NACK, 2'b00});
		xfer(1'b1, 7'h11, 16'h0000, 3'd1, {ACK_NACK, 2'b00});
		$display("Refusal transfers done");
		i2c_master_en <= 1'b1;
		repeat (2) @(posedge ref_clk);
		check(scl_oe, 1'b1);
		xfer(1'b0, 7'h50, 16'h0040, 3'd1, 4'h0);
		check(ext_tgt_seen, 7'h50);
		check(ext_len_seen, 8'h05);
		check(extq.size(), 6);
		check(extq[0], 8'h00);
		check(extq[1], 8'h40);
		check(extq[2], wq[0][7:0]);
		check(extq[5], wq[0][31:24]);
		xfer(1'b1, 7'h50, 16'h0000, 3'd2, 4'h0);
		check(ext_cmd_seen, CMD_READ);
		check(rq[0], fwd_word(0));
		check(rq[1], fwd_word(1));
		rd_chk(16'h0168, 3'd1);
		i2c_master_en <= 1'b0;
		$display("Forwarding transfers done");
		reset_dut(1'b1);
		xfer(1'b0, TGT_DEFAULT, 16'h0100, 3'd1, {ACK_NACK, 2'b00});
		wq[0] = $urandom;
		xfer(1'b0, own, 16'h0100, 3'd1, 4'h0);
		rd_chk(16'h0100, 3'd1);
		$display("Strapped address done");
		wrap_up();
	end
endmodule : test_aux_register_access_bridge
